// File: core/ccr_pkg.sv
// ccr_pkg: register map, field positions, reset values and carrier types
// of the comparator control block. Used by every core/ file.
package ccr_pkg;

    // register offsets (word index on the plain register port)
    localparam logic [2:0] CCR_OFF_CTRL = 3'h0;
    localparam logic [2:0] CCR_OFF_CODE = 3'h1;
    localparam logic [2:0] CCR_OFF_IRQ_STAT = 3'h2;
    localparam logic [2:0] CCR_OFF_IRQ_MASK = 3'h3;

    // control register field positions
    localparam int CCR_BIT_ENABLE = 15;
    localparam int CCR_BIT_STOP_IDLE = 13;
    localparam int CCR_BIT_DAC_OE = 8;
    localparam int CCR_BIT_SEL_HI = 7;
    localparam int CCR_BIT_SEL_LO = 6;
    localparam int CCR_BIT_OUTSIDE_REF = 5;
    localparam int CCR_BIT_STATE = 3;
    localparam int CCR_BIT_INVERT = 1;
    localparam int CCR_BIT_RANGE = 0;

    // writable bits of the control and code registers; reserved bits are zero here
    localparam logic [15:0] CCR_CTRL_WMASK = 16'hA1E3;
    localparam logic [15:0] CCR_CODE_WMASK = 16'h03FF;

    // values after reset
    localparam logic [15:0] CCR_CTRL_RST = 16'h0000;
    localparam logic [9:0] CCR_CODE_RST = 10'h000;
    localparam logic [1:0] CCR_IRQ_RST = 2'h0;

    // glitch filter: pulses shorter than this many cycles are rejected
    localparam int CCR_FILT_CYCLES = 2;
    // interrupt status bits: rising and falling event
    localparam int CCR_IRQ_RISE = 0;
    localparam int CCR_IRQ_FALL = 1;

    // positive input choice
    typedef enum logic [1:0] {
        CCR_IN_A = 2'h0,
        CCR_IN_B = 2'h1,
        CCR_IN_C = 2'h2,
        CCR_IN_D = 2'h3
    } ccr_insel_t;

    // settings handed to the analog macro
    typedef struct packed {
        logic power_on;
        logic dac_pin_output_enable;
        ccr_insel_t input_source_select;
        logic outside_reference_select;
        logic half_supply_range;
        logic [9:0] reference_code;
    } ccr_analog_t;

    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ccr_req_t;

endpackage : ccr_pkg

// File: core/ccr_sync.sv
// ccr_sync: two flip-flop synchroniser for one asynchronous level.
// Assumes the input is a level from another domain; the first stage is
// read only by the second.
`timescale 1ns/10ps
`default_nettype none
module ccr_sync
    import ccr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // level in and out
    input wire logic d,
    output logic q
);
    logic meta_r;

    // two stages, reset to low
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : ccr_sync
`default_nettype wire

// File: core/ccr_filter.sv
// ccr_filter: glitch filter; output follows input only after the input
// has held steady for CYCLES clock cycles. Assumes a synchronous input.
`timescale 1ns/10ps
`default_nettype none
module ccr_filter
    import ccr_pkg::*;
#(
    parameter int CYCLES = CCR_FILT_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filtered level
    input wire logic d,
    output logic q
);
    logic [3:0] cnt_r;

    // count disagreement between input and output, update when long enough
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= 4'h0;
            q <= 1'b0;
        end
        else if (d == q)
        begin
            cnt_r <= 4'h0;
        end
        else if (cnt_r == 4'(CYCLES - 1))
        begin
            cnt_r <= 4'h0;
            q <= d;
        end
        else
        begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule : ccr_filter
`default_nettype wire

// File: core/ccr_top.sv
// ccr_top: control and status logic for one high-speed comparator channel
// with its 10-bit reference DAC. Assumes a register master on CLK_SYS that
// keeps to one-cycle strobes, an analog macro that takes the settings and
// returns a raw asynchronous comparator output, and a power controller
// that reports idle and sleep as levels on CLK_SYS.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - enable bit powers comparator and DAC
// - stop-in-idle halts channel in idle
// - any stop-in-idle stops all in idle
// - control reserved bits read zero
// - pin enable connects DAC to pin
// - select field steers positive input mux
// - outside reference bit picks reference source
// - state bit shows polarity-adjusted output
// - invert bit flips output everywhere
// - range bit picks half-supply or low
// - ten-bit code drives the DAC
// - code register upper bits read zero
// - all writable bits clear at reset
// - running output glitch-filtered two cycles
// - sleep or idle: wake output bypasses filter
// - each rising event gives one-cycle pulse
module ccr_top
    import ccr_pkg::*;
(
    // system clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // register port
    input wire logic [2:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // power state from the device
    input wire logic IDLE_MODE,
    input wire logic SLEEP_MODE,
    input wire logic ANY_STOP_IN_IDLE,
    output logic STOP_IN_IDLE_REQ,
    // analog macro
    output ccr_analog_t ANALOG_CFG,
    input wire logic CMP_RAW,
    // comparator output uses
    output logic CMP_OUT,
    output logic CMP_WAKE,
    output logic EVENT_PULSE,
    output logic IRQ
);
    ccr_req_t req;
    logic [15:0] ctrl_r;
    logic [9:0] code_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_set;
    logic raw_sync;
    logic pol_sync;
    logic filt_out;
    logic filt_prev_r;
    logic run;
    logic halted;
    logic [15:0] ctrl_view;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // masked write helper for registers with reserved bits
    function automatic logic [15:0] ccr_wr(input logic [15:0] v,
                                          input logic [15:0] m);
        ccr_wr = v & m;
    endfunction : ccr_wr

    // control register; reserved bits never stored
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            ctrl_r <= CCR_CTRL_RST;
        else if (req.wr && req.addr == CCR_OFF_CTRL)
            ctrl_r <= ccr_wr(req.wdata, CCR_CTRL_WMASK);
    end

    // reference code register
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            code_r <= CCR_CODE_RST;
        else if (req.wr && req.addr == CCR_OFF_CODE)
            code_r <= req.wdata[9:0];
    end

    // idle halt: own bit or any other channel's bit
    assign STOP_IN_IDLE_REQ = ctrl_r[CCR_BIT_STOP_IDLE];
    assign halted = IDLE_MODE
                    && (ctrl_r[CCR_BIT_STOP_IDLE] || ANY_STOP_IN_IDLE);
    assign run = ctrl_r[CCR_BIT_ENABLE] && !halted;

    // settings to the analog macro
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            ANALOG_CFG <= '0;
        else
        begin
            ANALOG_CFG.power_on <= run;
            // pin drive; software keeps this unique among channels
            ANALOG_CFG.dac_pin_output_enable <=
                run && ctrl_r[CCR_BIT_DAC_OE];
            ANALOG_CFG.input_source_select <= ccr_insel_t'(
                ctrl_r[CCR_BIT_SEL_HI:CCR_BIT_SEL_LO]);
            ANALOG_CFG.outside_reference_select <=
                ctrl_r[CCR_BIT_OUTSIDE_REF];
            ANALOG_CFG.half_supply_range <= ctrl_r[CCR_BIT_RANGE];
            ANALOG_CFG.reference_code <= code_r;
        end
    end

    // raw comparator output into the clock domain
    ccr_sync u_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .d(CMP_RAW),
        .q(raw_sync)
    );

    // polarity, gated inactive while not running
    assign pol_sync = run && (raw_sync ^ ctrl_r[CCR_BIT_INVERT]);

    // glitch filter on the running path
    ccr_filter #(
        .CYCLES(CCR_FILT_CYCLES)
    ) u_filt (
        .clk(CLK_SYS),
        .rst(RST),
        .d(pol_sync),
        .q(filt_out)
    );

    // asynchronous wake path bypasses the filter in low power
    assign CMP_WAKE = ctrl_r[CCR_BIT_ENABLE] && (SLEEP_MODE || IDLE_MODE)
                      && !halted
                      && (CMP_RAW ^ ctrl_r[CCR_BIT_INVERT]);

    // filtered output and edge pulse
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            filt_prev_r <= 1'b0;
            CMP_OUT <= 1'b0;
            EVENT_PULSE <= 1'b0;
        end
        else
        begin
            filt_prev_r <= filt_out;
            CMP_OUT <= filt_out;
            EVENT_PULSE <= filt_out && !filt_prev_r;
        end
    end

    // interrupt events: rising and falling edges of the filtered output
    assign irq_set = {!filt_out && filt_prev_r,
                      filt_out && !filt_prev_r};

    // sticky status, write one to clear, set wins over clear
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            irq_stat_r <= CCR_IRQ_RST;
        else if (req.wr && req.addr == CCR_OFF_IRQ_STAT)
            irq_stat_r <= (irq_stat_r & ~req.wdata[1:0]) | irq_set;
        else
            irq_stat_r <= irq_stat_r | irq_set;
    end

    // interrupt mask
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            irq_mask_r <= CCR_IRQ_RST;
        else if (req.wr && req.addr == CCR_OFF_IRQ_MASK)
            irq_mask_r <= req.wdata[1:0];
    end

    assign IRQ = |(irq_stat_r & irq_mask_r);

    // control view with live state bit
    always_comb
    begin
        ctrl_view = ctrl_r;
        ctrl_view[CCR_BIT_STATE] = filt_out;
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            RDATA <= 16'h0000;
        else if (req.rd)
        begin
            unique case (req.addr)
                CCR_OFF_CTRL: RDATA <= ctrl_view;
                CCR_OFF_CODE: RDATA <= {6'h00, code_r};
                CCR_OFF_IRQ_STAT: RDATA <= {14'h0, irq_stat_r};
                CCR_OFF_IRQ_MASK: RDATA <= {14'h0, irq_mask_r};
                default: RDATA <= 16'h0000;
            endcase
        end
        else
            RDATA <= 16'h0000;
    end
endmodule : ccr_top
`default_nettype wire

// File: testbench/ccr_analog_model.sv
// ccr_analog_model: behavioural comparator with its reference DAC.
// Assumes input levels are given in code units of the chosen reference.
`timescale 1ns/10ps
`default_nettype none
module ccr_analog_model
    import ccr_pkg::*;
(
    // settings and input levels
    input wire ccr_analog_t cfg,
    input wire logic [3:0][9:0] level,
    // raw output
    output logic cmp_raw
);
    // powered-down comparator stays low; mux picks the positive input
    always_comb
    begin
        cmp_raw = cfg.power_on
            && (level[cfg.input_source_select] > cfg.reference_code);
    end
endmodule : ccr_analog_model
`default_nettype wire

// File: testbench/ccr_assertions.sv
// ccr_assertions: port checks of the comparator control block.
// Assumes one-cycle register strobes from the bench.
`timescale 1ns/10ps
`default_nettype none
module ccr_assertions
    import ccr_pkg::*;
(
    // clock, reset, register port
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [2:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    // power state and comparator
    input wire logic IDLE_MODE,
    input wire logic SLEEP_MODE,
    input wire logic ANY_STOP_IN_IDLE,
    input wire ccr_analog_t ANALOG_CFG,
    input wire logic CMP_OUT,
    input wire logic CMP_WAKE,
    input wire logic EVENT_PULSE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // code word written
    sequence code_wr_s;
        WR && ADDR == CCR_OFF_CODE;
    endsequence
    ctrl_rsv_a: assert property ($past(RD) && $past(ADDR) == 3'h0
        |-> (RDATA & ~(CCR_CTRL_WMASK | 16'h0008)) == 16'h0000)
        else $error("control reserved bit set");
    code_rsv_a: assert property ($past(RD) && $past(ADDR) == 3'h1
        |-> RDATA[15:10] == 6'h00) else $error("code upper bits set");
    code_cfg_a: assert property (code_wr_s
        |=> ##1 ANALOG_CFG.reference_code == $past(WDATA[9:0], 2))
        else $error("reference code not passed on");
    pulse_edge_a: assert property (EVENT_PULSE
        |-> CMP_OUT && !$past(CMP_OUT)) else $error("pulse off edge");
    pulse_one_a: assert property (EVENT_PULSE |=> !EVENT_PULSE)
        else $error("pulse too long");
    off_out_a: assert property (!ANALOG_CFG.power_on [*6]
        |-> !CMP_OUT) else $error("output while disabled");
    stop_all_a: assert property ((IDLE_MODE && ANY_STOP_IN_IDLE) [*6]
        |-> !CMP_OUT) else $error("output while halted");
    wake_run_a: assert property (!SLEEP_MODE && !IDLE_MODE
        |-> !CMP_WAKE) else $error("wake path while running");
endmodule : ccr_assertions
bind ccr_top ccr_assertions u_ccr_assertions (.CLK_SYS(CLK_SYS),
    .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IDLE_MODE(IDLE_MODE), .SLEEP_MODE(SLEEP_MODE),
    .ANY_STOP_IN_IDLE(ANY_STOP_IN_IDLE), .ANALOG_CFG(ANALOG_CFG),
    .CMP_OUT(CMP_OUT), .CMP_WAKE(CMP_WAKE), .EVENT_PULSE(EVENT_PULSE));
`default_nettype wire

// File: testbench/tb.sv
// tb: register and comparator-path tests of the control block.
// Assumes the analog model in place of the comparator macro.
`timescale 1ns/10ps
`default_nettype none
module tb
    import ccr_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic idle = 1'b0;
    logic sleep = 1'b0;
    logic stop = 1'b0;
    logic [3:0][9:0] lvl = '0;
    logic [15:0] rdata;
    logic sreq, raw, cout, wake, pls, irq;
    ccr_analog_t cfg;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int pn = 0;
    int p0;
    ccr_top u_ccr_top (.CLK_SYS(clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IDLE_MODE(idle),
        .SLEEP_MODE(sleep), .ANY_STOP_IN_IDLE(stop), .STOP_IN_IDLE_REQ(sreq),
        .ANALOG_CFG(cfg), .CMP_RAW(raw), .CMP_OUT(cout), .CMP_WAKE(wake),
        .EVENT_PULSE(pls), .IRQ(irq));
    ccr_analog_model u_ccr_analog_model (.cfg(cfg), .level(lvl),
        .cmp_raw(raw));
    always #2 clk = ~clk;
    // cycle ceiling and pulse count
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        pn <= pn + int'(pls === 1'b1);
        if (cyc == 3000)
        begin
            fail_count = fail_count + 1;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("BAD %0t got %h want %h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wrr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    task automatic rdc(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rdc
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++)
            rdc(a[2:0], 16'h0000);
        wrr(CCR_OFF_IRQ_MASK, 16'h0003);
        wrr(CCR_OFF_CTRL, 16'hFFFF);
        wrr(CCR_OFF_CODE, 16'hFFFF);
        step(8);
        rdc(CCR_OFF_CTRL, 16'hA1EB);
        rdc(CCR_OFF_CODE, 16'h03FF);
        chk(cfg, 16'hFFFF);
        chk({15'h0, sreq}, 16'h0001);
        rdc(CCR_OFF_IRQ_STAT, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        wrr(CCR_OFF_IRQ_STAT, 16'h0003);
        step(2);
        chk({15'h0, irq}, 16'h0000);
        wrr(CCR_OFF_CODE, 16'h0100);
        for (int s = 0; s < 4; s++)
        begin
            lvl <= 40'(10'h200) << (10 * s);
            wrr(CCR_OFF_CTRL, {8'h80, s[1:0], 6'h00});
            step(8);
            chk({15'h0, cout}, 16'h0001);
        end
        lvl <= '0;
        step(8);
        wrr(CCR_OFF_IRQ_STAT, 16'h0003);
        p0 = pn;
        lvl[3] <= 10'h3FF;
        step(10);
        chk(16'(pn - p0), 16'h0001);
        rdc(CCR_OFF_IRQ_STAT, 16'h0001);
        wrr(CCR_OFF_IRQ_MASK, 16'h0002);
        step(2);
        chk({15'h0, irq}, 16'h0000);
        @(posedge clk);
        lvl[3] <= 10'h000;
        @(posedge clk);
        lvl[3] <= 10'h3FF;
        step(10);
        chk({15'h0, cout}, 16'h0001);
        rdc(CCR_OFF_IRQ_STAT, 16'h0001);
        idle <= 1'b1;
        stop <= 1'b1;
        step(8);
        chk({15'h0, cout}, 16'h0000);
        stop <= 1'b0;
        step(8);
        chk({15'h0, cout}, 16'h0001);
        chk({15'h0, wake}, 16'h0001);
        // own stop-in-idle bit halts the channel by itself
        wrr(CCR_OFF_CTRL, 16'hA0C0);
        step(8);
        chk({15'h0, cout}, 16'h0000);
        chk({15'h0, wake}, 16'h0000);
        chk({15'h0, sreq}, 16'h0001);
        wrr(CCR_OFF_CTRL, 16'h80C0);
        idle <= 1'b0;
        sleep <= 1'b1;
        step(2);
        chk({15'h0, wake}, 16'h0001);
        sleep <= 1'b0;
        wrr(CCR_OFF_CTRL, 16'h0000);
        step(8);
        chk({15'h0, cout}, 16'h0000);
        chk(cfg, 16'h0100);
        // reset in mid-run clears the code and mask registers and the analog settings again
        wrr(CCR_OFF_IRQ_MASK, 16'h0003);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(CCR_OFF_CODE, 16'h0000);
        rdc(CCR_OFF_IRQ_MASK, 16'h0000);
        chk(cfg, 16'h0000);
        close_out();
    end
endmodule : tb
`default_nettype wire
